//--- hw/reset_init_pkg.sv
package reset_init_pkg;

  // register indices on the plain register port
  localparam int         REG_N      = 21;
  localparam logic [4:0] IDX_BANK   = 5'h00;
  localparam logic [4:0] IDX_PCL    = 5'h01;
  localparam logic [4:0] IDX_TBC    = 5'h02;
  localparam logic [4:0] IDX_INTERRUPT_CONTROL_0  = 5'h03;
  localparam logic [4:0] IDX_TIMER0_COUNT   = 5'h04;
  localparam logic [4:0] IDX_TIMER0_CONTROL  = 5'h05;
  localparam logic [4:0] IDX_TIMER1_CONTROL  = 5'h06;
  localparam logic [4:0] IDX_TIMER2_CONTROL  = 5'h07;
  localparam logic [4:0] IDX_TIMER3_CONTROL  = 5'h08;
  localparam logic [4:0] IDX_PORTS  = 5'h09;
  localparam logic [4:0] IDX_PULSE_WIDTH0_HIGH  = 5'h11;
  localparam logic [4:0] IDX_INTERRUPT_CONTROL_1  = 5'h12;
  localparam logic [4:0] IDX_STATUS = 5'h13;
  localparam logic [4:0] IDX_STACK  = 5'h14;

  // preset values, by index
  localparam logic [7:0] RST_VAL [REG_N] = '{
    8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h08, 8'h01, 8'h08, 8'h08,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00};
  // implemented bits, by index
  localparam logic [7:0] IMPL_MASK [REG_N] = '{
    8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hdf, 8'h1f, 8'hdf, 8'hdf,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h1f, 8'h0f, 8'h0f};
  // registers preset by pin, droop and running watchdog resets
  localparam logic [REG_N-1:0] WARM_MASK = 21'h1fffef & ~21'h080000;
  // registers preset by a watchdog reset while halted
  localparam logic [REG_N-1:0] HALT_MASK = 21'h100002;

  localparam logic [7:0] STACK_TOP  = 8'h00;
  localparam int         DOG_BIT    = 5;
  localparam int         SLEEP_BIT  = 4;
  localparam int         RUN_BIT    = 4;
  localparam int         WDT_W      = 20;
  localparam int         PRESC_W    = 7;

  typedef enum logic [2:0] {
    RK_NONE,
    RK_POWER,
    RK_WARM,
    RK_DOG_RUN,
    RK_DOG_HALT
  } reset_kind_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [1:0]               pin_s;
    logic [1:0]               droop_s;
    logic                     sleep;
    logic                     dog;
    logic                     slp;
    logic [WDT_W-1:0]         wdt;
    logic [PRESC_W-1:0]       presc;
    logic [7:0]               rdata;
    logic                     restart;
    logic [REG_N-1:0][7:0]    regs;
  } state_t;

endpackage

//--- hw/reset_state_initialiser.sv
`timescale 1ns/1ps
module reset_state_initialiser
  import reset_init_pkg::*;
#(
  parameter int WDT_CYCLES = 65536
)(
  // clock and power-on reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // reset sources and core events
  input  wire logic        hard_clear_pin_b_in,
  input  wire logic        supply_droop_clear_in,
  input  wire logic        power_down_in,
  input  wire logic        wake_in,
  input  wire logic        dog_clear_in,
  // register port
  input  wire bus_req_t    bus_in,
  output logic [7:0]       rdata_out,
  // state seen by the core
  output logic             dog_expiry_flag_out,
  output logic             sleep_entry_flag_out,
  output logic             core_restart_out,
  output logic             sleeping_out,
  output logic [7:0]       program_counter_low_out,
  output logic [7:0]       stack_ptr_out,
  output logic [3:0]       timers_run_out,
  output logic             irq_enable_out
);

  state_t      st_reg;
  state_t      st_next;
  reset_kind_t kind;
  logic        dog_ovf;

  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

  function automatic reset_kind_t decode(input logic por, input logic warm,
                                         input logic ovf, input logic asleep);
    if (por)
      return RK_POWER;
    else if (ovf && asleep)
      return RK_DOG_HALT;
    else if (ovf)
      return RK_DOG_RUN;
    else if (warm)
      return RK_WARM;
    else
      return RK_NONE;
  endfunction

  assign dog_ovf = (st_reg.wdt == WDT_LAST);
  assign kind    = decode(!rst_b_in, !st_reg.pin_s[1] || st_reg.droop_s[1],
                          dog_ovf, st_reg.sleep);

  always_comb
  begin
    st_next         = st_reg;
    st_next.pin_s   = {st_reg.pin_s[0], hard_clear_pin_b_in};
    st_next.droop_s = {st_reg.droop_s[0], supply_droop_clear_in};
    st_next.restart = 1'b0;
    st_next.rdata   = 8'h00;
    st_next.wdt     = st_reg.wdt + WDT_W'(1);
    st_next.presc   = st_reg.presc + PRESC_W'(1);

    // core events first, so a reset in the same cycle overrides them
    if (power_down_in)
    begin
      st_next.sleep = 1'b1;
      st_next.slp   = 1'b1;
      st_next.dog   = 1'b0;
      st_next.wdt   = '0;
    end
    if (dog_clear_in)
    begin
      st_next.dog = 1'b0;
      st_next.slp = 1'b0;
      st_next.wdt = '0;
    end
    if (wake_in)
      st_next.sleep = 1'b0;

    // a reset in the same cycle wins over a register write
    if (bus_in.wr && bus_in.addr < IDX_STACK && kind == RK_NONE)
      st_next.regs[bus_in.addr] = bus_in.wdata & IMPL_MASK[bus_in.addr];
    if (bus_in.rd)
    begin
      if (bus_in.addr == IDX_STATUS)
      begin
        st_next.rdata            = st_reg.regs[IDX_STATUS];
        st_next.rdata[DOG_BIT]   = st_reg.dog;
        st_next.rdata[SLEEP_BIT] = st_reg.slp;
      end
      else if (bus_in.addr <= IDX_STACK)
        st_next.rdata = st_reg.regs[bus_in.addr];
    end

    case (kind)
      RK_POWER:
      begin
        st_next.dog   = 1'b0;
        st_next.slp   = 1'b0;
        st_next.presc = '0;
        for (int i = 0; i < REG_N; i++)
          st_next.regs[i] = RST_VAL[i];
        st_next.regs[IDX_STACK] = STACK_TOP;
      end
      RK_WARM, RK_DOG_RUN:
      begin
        // flags keep their values on a pin or droop reset
        // same-cycle sleep entry or watchdog clear must not leak through
        st_next.dog = st_reg.dog;
        st_next.slp = st_reg.slp;
        if (kind == RK_DOG_RUN)
          st_next.dog = 1'b1;
        st_next.presc = '0;
        for (int i = 0; i < REG_N; i++)
          if (WARM_MASK[i])
            st_next.regs[i] = RST_VAL[i];
      end
      RK_DOG_HALT:
      begin
        st_next.dog = 1'b1;
        st_next.slp = 1'b1;
        // only pc low and stack are touched; the rest is kept
        for (int i = 0; i < REG_N; i++)
          if (HALT_MASK[i])
            st_next.regs[i] = RST_VAL[i];
      end
      default:
      begin
      end
    endcase

    if (kind != RK_NONE)
    begin
      st_next.wdt           = '0;
      st_next.sleep         = 1'b0;
      st_next.restart       = 1'b1;
      st_next.regs[IDX_PCL] = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    st_reg <= st_next;
  end

  assign rdata_out               = st_reg.rdata;
  assign dog_expiry_flag_out     = st_reg.dog;
  assign sleep_entry_flag_out    = st_reg.slp;
  assign core_restart_out        = st_reg.restart;
  assign sleeping_out            = st_reg.sleep;
  assign program_counter_low_out = st_reg.regs[IDX_PCL];
  assign stack_ptr_out           = st_reg.regs[IDX_STACK];
  assign irq_enable_out          = st_reg.regs[IDX_INTERRUPT_CONTROL_0][0];
  assign timers_run_out          = {st_reg.regs[IDX_TIMER3_CONTROL][RUN_BIT],
                                    st_reg.regs[IDX_TIMER2_CONTROL][RUN_BIT],
                                    st_reg.regs[IDX_TIMER1_CONTROL][RUN_BIT],
                                    st_reg.regs[IDX_TIMER0_CONTROL][RUN_BIT]};

  // power-on checks cannot be disabled by the reset they watch
  chk_por_flags: assert property (@(posedge sys_clk_in)
    !rst_b_in |=> !dog_expiry_flag_out && !sleep_entry_flag_out)
    else $error("flags not cleared by power-on reset");

  chk_por_presets: assert property (@(posedge sys_clk_in)
    !rst_b_in && (!st_reg.pin_s[1] || st_reg.droop_s[1]) |=> st_reg.regs[IDX_PORTS] == 8'hff
      && timers_run_out == 4'h0 && !irq_enable_out && st_reg.presc == '0)
    else $error("power-on presets lost");

  chk_por_stack: assert property (@(posedge sys_clk_in)
    !rst_b_in |=> stack_ptr_out == STACK_TOP && st_reg.regs[IDX_INTERRUPT_CONTROL_1] == 8'h00)
    else $error("stack or interrupts wrong after power-on");

  chk_warm_flags: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_WARM
    |=> dog_expiry_flag_out == $past(st_reg.dog)
      && sleep_entry_flag_out == $past(st_reg.slp))
    else $error("pin reset altered flags");

  chk_dog_run: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_DOG_RUN
    |=> dog_expiry_flag_out
      && sleep_entry_flag_out == $past(st_reg.slp)
      && st_reg.regs[IDX_TIMER0_CONTROL] == 8'h08)
    else $error("running watchdog reset wrong");

  chk_dog_halt: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_DOG_HALT
    |=> dog_expiry_flag_out
      && sleep_entry_flag_out
      && st_reg.regs[IDX_PORTS] == $past(st_reg.regs[IDX_PORTS]))
    else $error("halted watchdog reset wrong");

  chk_halt_keep: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_DOG_HALT
    |=> $stable(timers_run_out)
      && $stable(irq_enable_out))
    else $error("halted watchdog reset touched registers");

  chk_pcl_zero: assert property (@(posedge sys_clk_in)
    kind != RK_NONE
    |=> program_counter_low_out == 8'h00
      && core_restart_out)
    else $error("pc low not cleared on reset");

  // first free cycle after a reset moves the counter from zero to one
  chk_wdt_restart: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind != RK_NONE ##1 (kind == RK_NONE && !power_down_in && !dog_clear_in)
    |=> st_reg.wdt == WDT_W'(1))
    else $error("watchdog not restarted");

  chk_sleep_entry: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    power_down_in && !dog_clear_in && !wake_in && kind == RK_NONE
    |=> sleep_entry_flag_out
      && !dog_expiry_flag_out
      && sleeping_out)
    else $error("sleep entry not recorded");

  chk_dog_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    dog_clear_in && kind == RK_NONE
    |=> !dog_expiry_flag_out
      && !sleep_entry_flag_out)
    else $error("watchdog clear left a flag set");

  chk_wake_plain: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wake_in && !power_down_in && kind == RK_NONE
    |=> !sleeping_out
      && sleep_entry_flag_out == $past(st_reg.slp))
    else $error("wake disturbed the flags");

  chk_wdt_count: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_NONE && !power_down_in && !dog_clear_in
    |=> st_reg.wdt == $past(st_reg.wdt) + WDT_W'(1))
    else $error("watchdog counter stalled");

  chk_por_others: assert property (@(posedge sys_clk_in)
    !rst_b_in
    |=> st_reg.regs[IDX_BANK] == 8'h00
      && st_reg.regs[IDX_TBC] == 8'h07
      && st_reg.regs[IDX_INTERRUPT_CONTROL_0] == 8'h00
      && st_reg.regs[IDX_PULSE_WIDTH0_HIGH] == 8'h00
      && st_reg.regs[IDX_TIMER0_COUNT] == 8'h00
      && st_reg.regs[IDX_STATUS] == 8'h00)
    else $error("power-on register presets wrong");

  chk_warm_presets: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_WARM || kind == RK_DOG_RUN
    |=> st_reg.regs[IDX_TIMER0_CONTROL] == 8'h08
      && st_reg.regs[IDX_TIMER1_CONTROL] == 8'h01
      && st_reg.regs[IDX_TIMER2_CONTROL] == 8'h08
      && st_reg.regs[IDX_TIMER3_CONTROL] == 8'h08
      && st_reg.regs[IDX_TBC] == 8'h07
      && st_reg.presc == '0)
    else $error("warm reset presets wrong");

  chk_halt_stack: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_DOG_HALT
    |=> stack_ptr_out == STACK_TOP
      && program_counter_low_out == 8'h00
      && core_restart_out
      && !sleeping_out)
    else $error("halted watchdog reset left pc or stack");

  chk_reset_wakes: assert property (@(posedge sys_clk_in)
    kind != RK_NONE
    |=> !sleeping_out)
    else $error("core left asleep after reset");

  chk_restart_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    kind == RK_NONE
    |=> !core_restart_out)
    else $error("restart pulse without reset");

  chk_stack_ro: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    bus_in.wr && kind == RK_NONE
    |=> $stable(stack_ptr_out))
    else $error("stack pointer written from the bus");

  chk_port_write: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    bus_in.wr && bus_in.addr == IDX_PORTS && kind == RK_NONE
    |=> st_reg.regs[IDX_PORTS] == $past(bus_in.wdata))
    else $error("register write lost");

  chk_rdata_idle: assert property (@(posedge sys_clk_in)
    !bus_in.rd
    |=> rdata_out == 8'h00)
    else $error("read data not idle");

  chk_status_read: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    bus_in.rd && bus_in.addr == IDX_STATUS
    |=> rdata_out[DOG_BIT] == $past(st_reg.dog)
      && rdata_out[SLEEP_BIT] == $past(st_reg.slp))
    else $error("status read lost a flag");

  // every port data and direction register, one check each
  for (genvar g = 0; g < 8; g++)
  begin : g_port_chk
    chk_port_preset: assert property (@(posedge sys_clk_in)
      kind == RK_POWER || kind == RK_WARM || kind == RK_DOG_RUN
      |=> st_reg.regs[int'(IDX_PORTS) + g] == 8'hff)
      else $error("port register not preset");
  end

  // registers outside the halt preset set hold through a halted watchdog reset
  for (genvar g = 0; g < REG_N; g++)
  begin : g_halt_chk
    if (HALT_MASK[g] == 1'b0)
    begin : g_kept
      chk_halt_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        kind == RK_DOG_HALT
        |=> st_reg.regs[g] == $past(st_reg.regs[g]))
        else $error("register changed by halted watchdog reset");
    end
  end

  cov_por_combo: cover property (@(posedge sys_clk_in) !rst_b_in && st_reg.droop_s[1]);

  cov_por: cover property (@(posedge sys_clk_in) !rst_b_in ##1 rst_b_in);
  cov_pin: cover property (@(posedge sys_clk_in) kind == RK_WARM);
  cov_dog_run: cover property (@(posedge sys_clk_in) kind == RK_DOG_RUN);
  cov_dog_halt: cover property (@(posedge sys_clk_in) kind == RK_DOG_HALT);

endmodule

//--- dv/reset_source_model.sv
`timescale 1ns/1ps
// drives the external pin and the supply monitor; n sets how long it holds
module reset_source_model (
  // clock
  input  wire logic clk_in,
  // reset requests
  output logic      pin_b_out,
  output logic      droop_out
);
  initial
  begin
    pin_b_out = 1'b1;
    droop_out = 1'b0;
  end
  task automatic hold(input int sel, input int n);
    @(posedge clk_in);
    if (sel == 0)
      pin_b_out <= 1'b0;
    else
      droop_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    pin_b_out <= 1'b1;
    droop_out <= 1'b0;
  endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import reset_init_pkg::*;
  localparam int W = 200;
  logic       sys_clk_in;
  logic       rst_b_in;
  logic [2:0] evt;
  bus_req_t   bus;
  logic [7:0] rdata, program_counter_low, sp;
  logic       dogf, slpf, rst_p, slp, irq;
  logic [3:0] trun;
  wire        pin_b, droop;
  int         num_errors = 0;
  int         checks = 0;

  reset_source_model src (.clk_in(sys_clk_in), .pin_b_out(pin_b), .droop_out(droop));
  reset_state_initialiser #(.WDT_CYCLES(W)) uut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .hard_clear_pin_b_in(pin_b),
    .supply_droop_clear_in(droop), .power_down_in(evt[2]), .wake_in(evt[1]),
    .dog_clear_in(evt[0]), .bus_in(bus), .rdata_out(rdata),
    .dog_expiry_flag_out(dogf), .sleep_entry_flag_out(slpf), .core_restart_out(rst_p),
    .sleeping_out(slp), .program_counter_low_out(program_counter_low), .stack_ptr_out(sp),
    .timers_run_out(trun), .irq_enable_out(irq));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic ev(input int i);
    @(posedge sys_clk_in);
    evt[i] <= 1'b1;
    @(posedge sys_clk_in);
    evt <= '0;
  endtask
  task automatic wait_restart(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (rst_p !== 1'b1 && n < W + 20);
  endtask

  task automatic t_por();
    for (int i = 0; i < REG_N; i++)
      rchk(i[4:0], RST_VAL[i]);
    rchk(5'h15, 8'h00);
    chk({trun, 3'h0, irq}, 8'h00);
    chk(program_counter_low, 8'h00);
  endtask
  task automatic t_warm(input int sel);
    wr(IDX_PORTS, 8'h5a);
    wr(IDX_TIMER0_CONTROL, 8'h10);
    ev(2);
    ev(1);
    #1 chk({7'h0, trun[0]}, 8'h01);
    src.hold(sel, 3 + sel * 4);
    repeat (6) @(posedge sys_clk_in);
    #1 chk({6'h0, dogf, slpf}, 8'h01);
    rchk(IDX_PORTS, 8'hff);
    chk({4'h0, trun}, 8'h00);
  endtask
  task automatic t_dog_run();
    int n;
    ev(0);
    wr(IDX_PORTS, 8'h33);
    wr(IDX_PCL, 8'h3c);
    ev(2);
    ev(1);
    wait_restart(n);
    chk(8'((n > W - 8) && (n < W + 2)), 8'h01);
    chk({6'h0, dogf, slpf}, 8'h03);
    chk(program_counter_low, 8'h00);
    rchk(IDX_PORTS, 8'hff);
  endtask
  task automatic t_dog_halt();
    int n;
    ev(0);
    wr(IDX_PORTS, 8'h33);
    wr(IDX_INTERRUPT_CONTROL_0, 8'h01);
    wr(IDX_TIMER0_CONTROL, 8'h10);
    wr(IDX_PCL, 8'h5c);
    ev(2);
    wait_restart(n);
    chk({5'h0, slp, dogf, slpf}, 8'h03);
    chk({3'h0, trun[0], 3'h0, irq}, 8'h11);
    chk(program_counter_low | sp, 8'h00);
    rchk(IDX_PORTS, 8'h33);
  endtask
  task automatic t_por_combo();
    wr(IDX_PORTS + 5'h1, 8'h00);
    ev(2);
    ev(1);
    fork
      src.hold(1, 4);
      begin
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
      end
    join
    repeat (6) @(posedge sys_clk_in);
    #1 chk({6'h0, dogf, slpf}, 8'h00);
    rchk(IDX_PORTS + 5'h1, 8'hff);
  endtask

  initial
  begin
    rst_b_in = 1'b0;
    evt = '0;
    bus = '0;
    repeat (20) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    t_por();
    t_warm(0);
    t_warm(1);
    t_dog_run();
    t_dog_halt();
    t_por_combo();
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    wrap_up();
  end
endmodule
